// *** pmd_pkg.sv ***
// Purpose: constants and types for the page mode memory controller
// Assumes: 200 MHz clock, one memory device of 256k x 1
// Notes:   timing figures in ns (power-up in us, refresh in ms), counts derived at 5 ns per cycle
package pmd_pkg;
  localparam int CLK_NS = 5;
  localparam int ADDR_W = 9;
  localparam int ROW_REFRESH_COUNT = 256;
  localparam int WAKE_CYCLES = 8;
  localparam int POWERUP_US = 100;
  localparam int REFRESH_MS = 4;
  localparam int ROW_ACTIVE_NS = 80;
  localparam int ROW_PRECHARGE_NS = 40;
  localparam int COL_ACTIVE_NS = 20;
  localparam int COLUMN_PRECHARGE_NS = 10;
  localparam int ROW_ADDR_HOLD_NS = 10;
  localparam int ROW_ACCESS_NS = 80;
  localparam int COLUMN_ADDR_ACCESS_NS = 35;
  localparam int WRITE_SETUP_NS = 0;
  localparam int WRITE_PULSE_NS = 15;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_W = 21;
  localparam int POWERUP_CYC = (POWERUP_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int REFRESH_CYC = (REFRESH_MS * 1000000) / CLK_NS;
  localparam int REFRESH_INTERVAL_CYC = REFRESH_CYC / ROW_REFRESH_COUNT;
  localparam int ROW_ACTIVE_CYC = (ROW_ACTIVE_NS + CLK_NS - 1) / CLK_NS;
  localparam int ROW_PRE_CYC = (ROW_PRECHARGE_NS + CLK_NS - 1) / CLK_NS;
  localparam int COL_ACTIVE_CYC = (COL_ACTIVE_NS + CLK_NS - 1) / CLK_NS;
  localparam int COL_PRE_CYC = (COLUMN_PRECHARGE_NS + CLK_NS - 1) / CLK_NS;
  localparam int ROW_HOLD_CYC = (ROW_ADDR_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int ROW_ACCESS_CYC = (ROW_ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int COL_ACCESS_CYC =
    (COLUMN_ADDR_ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int WRITE_PULSE_CYC = (WRITE_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int WRITE_SETUP_CYC = (WRITE_SETUP_NS + CLK_NS - 1) / CLK_NS > 0
    ? (WRITE_SETUP_NS + CLK_NS - 1) / CLK_NS : 1;
  localparam int CNT_W = 16;

  typedef enum logic [1:0] {
    PMD_OP_READ,
    PMD_OP_WRITE,
    PMD_OP_RMW
  } pmd_op_t;

  typedef struct packed {
    pmd_op_t             op;
    logic [ADDR_W-1:0]   row;
    logic [ADDR_W-1:0]   col;
    logic                wdata;
  } pmd_req_t;

  typedef struct packed {
    logic                row_strobe_n;
    logic                col_strobe_n;
    logic                write_n;
    logic [ADDR_W-1:0]   addr;
    logic                din;
  } pmd_pins_t;
endpackage : pmd_pkg

// *** pmd_fifo.sv ***
// Purpose: request buffer between the user port and the sequencer
// Assumes: single clock, first word fall through
// Notes:   full and empty come from a word count
`timescale 1ns/1ps
module pmd_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             i_clock,
  input  wire logic             i_rst_n,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign o_in_ready  = count != (AW+1)'(DEPTH);
  assign o_out_valid = count != '0;
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;
  assign o_out_data  = mem[rd_ptr];

  always_ff @(posedge i_clock) begin
    if (push) begin
      mem[wr_ptr] <= i_in_data;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : pmd_fifo

// *** pmd_ctrl.sv ***
// Purpose: controller that drives the page mode memory strobes and address
// Assumes: one device; data out pin arrives asynchronously
// Notes:   requests queue in a fifo; reads answer on o_rd_valid
`timescale 1ns/1ps
module pmd_ctrl #(
  parameter int POWERUP_CYC = pmd_pkg::POWERUP_CYC,
  parameter int REFRESH_INTERVAL_CYC = pmd_pkg::REFRESH_INTERVAL_CYC,
  parameter int REFRESH_CYC = pmd_pkg::REFRESH_CYC
) (
  input  wire logic                i_clock,
  input  wire logic                i_rst_n,
  input  wire logic                i_req_valid,
  output logic                     o_req_ready,
  input  wire pmd_pkg::pmd_req_t   i_req,
  output logic                     o_rd_valid,
  output logic                     o_rd_data,
  output logic                     o_init_done,
  output pmd_pkg::pmd_pins_t       o_pins,
  input  wire logic                i_dout
);
  typedef enum {
    ST_POWERUP,
    ST_WAKE_LOW,
    ST_WAKE_HIGH,
    ST_IDLE,
    ST_ROW_OPEN,
    ST_COL_LOW,
    ST_WRITE_LOW,
    ST_COL_PRE,
    ST_ROW_CLOSE,
    ST_REF_LOW,
    ST_PRECHARGE
  } pmd_state_t;

  pmd_state_t                   state;
  logic [pmd_pkg::CNT_W-1:0]    timer;
  logic [31:0]                  power_cnt;
  logic [31:0]                  ref_cnt;
  logic [31:0]                  idle_cnt;
  logic [3:0]                   wake_cnt;
  logic [7:0]                   ref_row;
  logic [6:0]                   row_cnt;
  logic                         ref_due;
  logic [pmd_pkg::ADDR_W-1:0]   open_row;
  logic                         fifo_valid;
  logic                         fifo_ready;
  pmd_pkg::pmd_req_t            head;
  pmd_pkg::pmd_req_t            cur;
  logic                         read_bit;
  logic                         dout_meta;
  logic                         dout_sync;
  logic                         timer_done;
  logic                         same_row;

  pmd_fifo #(
    .WIDTH (pmd_pkg::FIFO_W),
    .DEPTH (pmd_pkg::FIFO_DEPTH)
  ) u_fifo (
    .i_clock     (i_clock),
    .i_rst_n     (i_rst_n),
    .i_in_valid  (i_req_valid),
    .o_in_ready  (o_req_ready),
    .i_in_data   (i_req),
    .o_out_valid (fifo_valid),
    .i_out_ready (fifo_ready),
    .o_out_data  (head)
  );

  assign timer_done = timer == '0;
  assign same_row   = head.row == open_row;
  // a request is popped only when its column cycle begins
  assign fifo_ready = fifo_valid && timer_done && !ref_due &&
                      ((state == ST_ROW_OPEN) ||
                       (state == ST_COL_PRE && same_row));

  // data out pin is asynchronous to the clock
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dout_meta <= 1'b0;
      dout_sync <= 1'b0;
    end else begin
      dout_meta <= i_dout;
      dout_sync <= dout_meta;
    end
  end

  // pause after power-up before the wake-up cycles
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      power_cnt <= '0;
    end else if (power_cnt != 32'(POWERUP_CYC)) begin
      power_cnt <= power_cnt + 32'h1;
    end
  end

  // distributed refresh request, one row per interval
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ref_cnt <= '0;
      ref_due <= 1'b0;
    end else begin
      if (ref_cnt >= 32'(REFRESH_INTERVAL_CYC - 1)) begin
        ref_cnt <= '0;
      end else begin
        ref_cnt <= ref_cnt + 32'h1;
      end
      if (state == ST_REF_LOW) begin
        ref_due <= 1'b0;
      end
      if (ref_cnt >= 32'(REFRESH_INTERVAL_CYC - 1) && o_init_done) begin
        ref_due <= 1'b1;
      end
    end
  end

  // standby watch: without row cycles for a period, wake again
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      idle_cnt <= '0;
    end else if (!o_pins.row_strobe_n || state == ST_POWERUP) begin
      idle_cnt <= '0;
    end else if (idle_cnt != 32'(REFRESH_CYC)) begin
      idle_cnt <= idle_cnt + 32'h1;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state       <= ST_POWERUP;
      timer       <= '0;
      wake_cnt    <= '0;
      ref_row     <= '0;
      row_cnt     <= '0;
      open_row    <= '0;
      cur         <= '0;
      read_bit    <= 1'b0;
      o_init_done <= 1'b0;
      o_rd_valid  <= 1'b0;
      o_rd_data   <= 1'b0;
      o_pins      <= '{row_strobe_n: 1'b1, col_strobe_n: 1'b1,
                       write_n: 1'b1, addr: '0, din: 1'b0};
    end else begin
      o_rd_valid <= 1'b0;
      if (!timer_done) begin
        timer <= timer - 1'b1;
      end
      unique case (state)
        ST_POWERUP: begin
          if (power_cnt == 32'(POWERUP_CYC) && timer_done) begin
            wake_cnt          <= '0;
            o_pins.row_strobe_n <= 1'b0;
            timer             <= pmd_pkg::CNT_W'(pmd_pkg::ROW_ACTIVE_CYC - 1);
            state             <= ST_WAKE_LOW;
          end
        end
        ST_WAKE_LOW: begin
          if (timer_done) begin
            o_pins.row_strobe_n <= 1'b1;
            timer <= pmd_pkg::CNT_W'(pmd_pkg::ROW_PRE_CYC - 1);
            wake_cnt <= wake_cnt + 4'h1;
            state <= ST_WAKE_HIGH;
          end
        end
        ST_WAKE_HIGH: begin
          if (timer_done) begin
            if (wake_cnt == 4'(pmd_pkg::WAKE_CYCLES)) begin
              o_init_done <= 1'b1;
              state <= ST_IDLE;
            end else begin
              o_pins.row_strobe_n <= 1'b0;
              timer <= pmd_pkg::CNT_W'(pmd_pkg::ROW_ACTIVE_CYC - 1);
              state <= ST_WAKE_LOW;
            end
          end
        end
        ST_IDLE: begin
          if (idle_cnt == 32'(REFRESH_CYC)) begin
            o_init_done <= 1'b0;
            state <= ST_POWERUP;
          end else if (ref_due) begin
            // row-only cycle on the lower eight bits
            o_pins.addr <= {1'b0, ref_row};
            o_pins.row_strobe_n <= 1'b0;
            ref_row <= ref_row + 8'h1;
            timer <= pmd_pkg::CNT_W'(pmd_pkg::ROW_ACTIVE_CYC - 1);
            state <= ST_REF_LOW;
          end else if (fifo_valid) begin
            o_pins.addr <= head.row;
            open_row <= head.row;
            o_pins.row_strobe_n <= 1'b0;
            row_cnt <= '0;
            timer <= pmd_pkg::CNT_W'(pmd_pkg::ROW_HOLD_CYC - 1);
            state <= ST_ROW_OPEN;
          end
        end
        ST_ROW_OPEN: begin
          if (row_cnt != 7'h7f) begin
            row_cnt <= row_cnt + 7'h1;
          end
          if (fifo_ready) begin
            cur <= head;
            // column address flows through before the strobe falls
            o_pins.addr <= head.col;
            o_pins.din <= head.wdata;
            // early write: write strobe low before column strobe
            o_pins.write_n <= head.op != pmd_pkg::PMD_OP_WRITE;
            timer <= pmd_pkg::CNT_W'(pmd_pkg::WRITE_SETUP_CYC - 1);
            state <= ST_COL_LOW;
          end else if (timer_done) begin
            state <= ST_ROW_CLOSE;
          end
        end
        ST_COL_LOW: begin
          if (row_cnt != 7'h7f) begin
            row_cnt <= row_cnt + 7'h1;
          end
          if (timer_done && o_pins.col_strobe_n) begin
            o_pins.col_strobe_n <= 1'b0;
            // wait out row access or column address access, whichever ends later, plus sync
            timer <= pmd_pkg::CNT_W'(
              (pmd_pkg::ROW_ACCESS_CYC > 32'(row_cnt) + 32'(pmd_pkg::COL_ACCESS_CYC)
               ? pmd_pkg::ROW_ACCESS_CYC - 32'(row_cnt)
               : pmd_pkg::COL_ACCESS_CYC) + 1);
          end else if (timer_done) begin
            if (cur.op == pmd_pkg::PMD_OP_WRITE) begin
              // device times the write internally
              o_pins.col_strobe_n <= 1'b1;
              o_pins.write_n <= 1'b1;
              timer <= pmd_pkg::CNT_W'(pmd_pkg::COL_PRE_CYC - 1);
              state <= ST_COL_PRE;
            end else begin
              // output held while column strobe low
              read_bit <= dout_sync;
              if (cur.op == pmd_pkg::PMD_OP_RMW) begin
                o_pins.din <= cur.wdata;
                o_pins.write_n <= 1'b0;
                timer <= pmd_pkg::CNT_W'(pmd_pkg::WRITE_PULSE_CYC - 1);
                state <= ST_WRITE_LOW;
              end else begin
                o_rd_valid <= 1'b1;
                o_rd_data <= dout_sync;
                o_pins.col_strobe_n <= 1'b1;
                timer <= pmd_pkg::CNT_W'(pmd_pkg::COL_PRE_CYC - 1);
                state <= ST_COL_PRE;
              end
            end
          end
        end
        ST_WRITE_LOW: begin
          if (timer_done) begin
            o_rd_valid <= 1'b1;
            o_rd_data <= read_bit;
            o_pins.write_n <= 1'b1;
            o_pins.col_strobe_n <= 1'b1;
            timer <= pmd_pkg::CNT_W'(pmd_pkg::COL_PRE_CYC - 1);
            state <= ST_COL_PRE;
          end
        end
        ST_COL_PRE: begin
          // stay in the open row when the next column is in the same row and no refresh is due
          if (row_cnt != 7'h7f) begin
            row_cnt <= row_cnt + 7'h1;
          end
          if (fifo_ready) begin
            cur <= head;
            o_pins.addr <= head.col;
            o_pins.din <= head.wdata;
            o_pins.write_n <= head.op != pmd_pkg::PMD_OP_WRITE;
            timer <= pmd_pkg::CNT_W'(pmd_pkg::WRITE_SETUP_CYC - 1);
            state <= ST_COL_LOW;
          end else if (timer_done) begin
            state <= ST_ROW_CLOSE;
          end
        end
        ST_ROW_CLOSE: begin
          if (timer_done && 32'(row_cnt) >= pmd_pkg::ROW_ACTIVE_CYC) begin
            o_pins.row_strobe_n <= 1'b1;
            timer <= pmd_pkg::CNT_W'(pmd_pkg::ROW_PRE_CYC - 1);
            state <= ST_PRECHARGE;
          end else if (row_cnt != 7'h7f) begin
            row_cnt <= row_cnt + 7'h1;
          end
        end
        ST_REF_LOW: begin
          if (timer_done) begin
            o_pins.row_strobe_n <= 1'b1;
            timer <= pmd_pkg::CNT_W'(pmd_pkg::ROW_PRE_CYC - 1);
            state <= ST_PRECHARGE;
          end
        end
        ST_PRECHARGE: begin
          if (timer_done) begin
            state <= ST_IDLE;
          end
        end
      endcase
    end
  end
endmodule : pmd_ctrl

// *** pmd_ctrl_sva.sv ***
// Purpose: timing checks on the memory pins of the controller
// Assumes: one clock domain, strobes active low
// Notes:   counts follow the designer's cycle figures
`timescale 1ns/1ps
module pmd_ctrl_chk (
  input wire logic               i_clock,
  input wire logic               i_rst_n,
  input wire logic               o_init_done,
  input wire logic               o_rd_valid,
  input wire pmd_pkg::pmd_pins_t o_pins
);
  logic [15:0] low_cnt;
  logic [3:0]  wake_cnt;
  logic        ras_q;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) low_cnt <= '0;
    else if (!o_pins.row_strobe_n) low_cnt <= low_cnt + 16'h1;
    else low_cnt <= '0;
  end
  // counts row strobe falls of the current wake-up
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ras_q    <= 1'b1;
      wake_cnt <= '0;
    end else begin
      ras_q <= o_pins.row_strobe_n;
      if (o_init_done) wake_cnt <= '0;
      else if (ras_q && !o_pins.row_strobe_n) wake_cnt <= wake_cnt + 4'h1;
    end
  end
  sequence row_pre_s; o_pins.row_strobe_n [*8]; endsequence
  sequence col_pre_s; o_pins.col_strobe_n [*2]; endsequence
  ras_active_min_a: assert property (
    $rose(o_pins.row_strobe_n) |-> low_cnt >= 16'(pmd_pkg::ROW_ACTIVE_CYC))
    else $error("row strobe low too short");
  ras_precharge_a: assert property (
    $rose(o_pins.row_strobe_n) |-> row_pre_s)
    else $error("row precharge too short");
  cas_precharge_a: assert property (
    $rose(o_pins.col_strobe_n) |-> col_pre_s)
    else $error("column precharge too short");
  cas_in_row_a: assert property (
    !o_pins.col_strobe_n |-> !o_pins.row_strobe_n)
    else $error("column strobe outside row cycle");
  row_addr_hold_a: assert property (
    $fell(o_pins.row_strobe_n) |=> $stable(o_pins.addr))
    else $error("row address not held");
  col_addr_setup_a: assert property (
    $fell(o_pins.col_strobe_n) |-> $stable(o_pins.addr))
    else $error("column address not set up");
  early_data_a: assert property (
    $fell(o_pins.col_strobe_n) && !o_pins.write_n |-> $stable(o_pins.din))
    else $error("write data not set up");
  write_in_row_a: assert property (
    $fell(o_pins.write_n) |-> !o_pins.row_strobe_n)
    else $error("write strobe outside row cycle");
  no_early_access_a: assert property (
    !o_init_done |-> o_pins.col_strobe_n && !o_rd_valid)
    else $error("access before wake-up done");
  wake_count_a: assert property (
    $rose(o_init_done) |-> wake_cnt == 4'h8)
    else $error("wake-up pulse count wrong");
endmodule : pmd_ctrl_chk

// *** pmd_mem_model.sv ***
// Purpose: behavioural model of the 256k x 1 page mode memory
// Assumes: strobes active low, data out floats when not driven
// Notes:   o_err flags an access before the wake-up is complete
`timescale 1ns/1ps
module pmd_mem_model #(
  parameter int ACC_NS = 10
) (
  input  wire logic       i_row_strobe_n,
  input  wire logic       i_col_strobe_n,
  input  wire logic       i_write_n,
  input  wire logic [8:0] i_addr,
  input  wire logic       i_din,
  input  wire logic       i_slow,
  output logic            o_dout,
  output logic            o_err
);
  logic     mem [0:262143];
  logic [8:0] row;
  logic [8:0] col;
  logic     valid;
  logic     q;
  int       wake;
  realtime  last;
  initial begin
    wake  = 0;
    last  = 0;
    o_err = 1'b0;
    valid = 1'b0;
  end
  // only the row strobe refreshes and wakes the device
  always @(negedge i_row_strobe_n) begin
    row = i_addr;
    if ($realtime - last > 4.0e6) wake = 0;
    last = $realtime;
    if (wake < 8) wake = wake + 1;
  end
  // column latched at fall; early write or delayed read
  always @(negedge i_col_strobe_n) begin
    col   = i_addr;
    valid = 1'b0;
    if (i_row_strobe_n || wake < 8) o_err = 1'b1;
    if (!i_write_n) mem[{row, col}] = i_din;
    else begin
      #(i_slow ? 3 * ACC_NS : ACC_NS);
      q     = mem[{row, col}];
      valid = !i_col_strobe_n;
    end
  end
  // late write strobe stores data at the later fall
  always @(negedge i_write_n) begin
    if (!i_row_strobe_n && !i_col_strobe_n) mem[{row, col}] = i_din;
  end
  always @(posedge i_col_strobe_n) valid = 1'b0;
  // floats with column strobe high or no read bit ready
  assign o_dout = (!i_col_strobe_n && valid) ? q : 1'bz;
endmodule : pmd_mem_model

// *** tb_pmd_ctrl.sv ***
// Purpose: self-checking bench for the page mode memory controller
// Assumes: shortened power-up and refresh counts
// Notes:   expected bits come from a shadow copy of written cells
`timescale 1ns/1ps
module tb_pmd_ctrl;
  localparam int PU = 50;
  localparam int RI = 200;
  logic               i_clock, i_rst_n, i_req_valid, slow, dout, merr;
  logic               o_req_ready, o_rd_valid, o_rd_data, o_init_done;
  pmd_pkg::pmd_req_t  i_req;
  pmd_pkg::pmd_pins_t o_pins;
  int                 miscompares, n_compared;
  logic               rd_q[$];
  logic               exp_q[$];
  logic               shadow[int];
  logic               full_seen;
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin \
  miscompares++; $display("ERROR %s expected %h seen %h", nm, ex, got); \
  end end
  pmd_ctrl #(.POWERUP_CYC(PU), .REFRESH_INTERVAL_CYC(RI),
    .REFRESH_CYC(5000)) dut (.i_clock(i_clock), .i_rst_n(i_rst_n),
    .i_req_valid(i_req_valid), .o_req_ready(o_req_ready), .i_req(i_req),
    .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data),
    .o_init_done(o_init_done), .o_pins(o_pins), .i_dout(dout));
  pmd_mem_model #(.ACC_NS(10)) mem (.i_row_strobe_n(o_pins.row_strobe_n),
    .i_col_strobe_n(o_pins.col_strobe_n), .i_write_n(o_pins.write_n),
    .i_addr(o_pins.addr), .i_din(o_pins.din), .i_slow(slow),
    .o_dout(dout), .o_err(merr));
  initial begin
    i_clock = 1'b0;
    forever #2.5 i_clock = ~i_clock;
  end
  always @(negedge i_clock) if (o_rd_valid === 1'b1) rd_q.push_back(o_rd_data);
  task automatic push(input pmd_pkg::pmd_op_t op, input logic [8:0] r,
                      input logic [8:0] c, input logic d);
    logic rdy;
    i_req_valid <= 1'b1;
    i_req       <= '{op, r, c, d};
    if (op != pmd_pkg::PMD_OP_WRITE) exp_q.push_back(shadow[{r, c}]);
    if (op != pmd_pkg::PMD_OP_READ) shadow[{r, c}] = d;
    do begin
      @(negedge i_clock);
      rdy = o_req_ready;
      if (rdy !== 1'b1) full_seen = 1'b1;
      @(posedge i_clock);
    end while (rdy !== 1'b1);
  endtask : push
  task automatic drain(input string nm);
    int k;
    logic e, g;
    i_req_valid <= 1'b0;
    k = 0;
    while (rd_q.size() < exp_q.size() && k < 8000) begin
      @(posedge i_clock);
      k++;
    end
    repeat (60) @(posedge i_clock);
    `CHK("read count", exp_q.size(), rd_q.size())
    // pop once: the macro reads its arguments more than once
    while (exp_q.size() > 0 && rd_q.size() > 0) begin
      e = exp_q.pop_front();
      g = rd_q.pop_front();
      `CHK("read bit", e, g)
    end
    exp_q.delete();
    rd_q.delete();
    $display("test %s done", nm);
  endtask : drain
  task automatic t_init;
    int k;
    int lo;
    k = 0;
    lo = PU + pmd_pkg::WAKE_CYCLES * pmd_pkg::ROW_ACTIVE_CYC +
         (pmd_pkg::WAKE_CYCLES - 1) * pmd_pkg::ROW_PRE_CYC;
    while (o_init_done !== 1'b1 && k < 2000) begin
      @(posedge i_clock);
      k++;
    end
    `CHK("init done", 1'b1, o_init_done)
    `CHK("init time", 1'b1, k >= lo)
    $display("test init done");
  endtask : t_init
  task automatic t_page;
    push(pmd_pkg::PMD_OP_WRITE, 9'h1ff, 9'h000, 1'b1);
    push(pmd_pkg::PMD_OP_WRITE, 9'h1ff, 9'h1ff, 1'b0);
    push(pmd_pkg::PMD_OP_WRITE, 9'h000, 9'h000, 1'b0);
    push(pmd_pkg::PMD_OP_WRITE, 9'h1ff, 9'h005, 1'b1);
    push(pmd_pkg::PMD_OP_READ, 9'h1ff, 9'h1ff, 1'b0);
    push(pmd_pkg::PMD_OP_READ, 9'h1ff, 9'h000, 1'b0);
    push(pmd_pkg::PMD_OP_READ, 9'h000, 9'h000, 1'b0);
    push(pmd_pkg::PMD_OP_READ, 9'h1ff, 9'h005, 1'b0);
    drain("page");
  endtask : t_page
  task automatic t_rmw;
    slow <= 1'b1;
    push(pmd_pkg::PMD_OP_WRITE, 9'h003, 9'h007, 1'b1);
    push(pmd_pkg::PMD_OP_RMW, 9'h003, 9'h007, 1'b0);
    push(pmd_pkg::PMD_OP_RMW, 9'h003, 9'h007, 1'b1);
    push(pmd_pkg::PMD_OP_READ, 9'h003, 9'h007, 1'b0);
    drain("rmw");
    slow <= 1'b0;
  endtask : t_rmw
  task automatic t_fill;
    full_seen = 1'b0;
    for (int i = 0; i < 24; i++)
      push(pmd_pkg::PMD_OP_WRITE, 9'h002, 9'(i), i[0]);
    for (int i = 0; i < 24; i++)
      push(pmd_pkg::PMD_OP_READ, 9'h002, 9'(i), 1'b0);
    `CHK("fifo refused", 1'b1, full_seen)
    drain("fill");
  endtask : t_fill
  task automatic t_refresh;
    int n;
    logic cas_low, prev;
    n = 0;
    cas_low = 1'b0;
    // a pulse already under way at the start belongs to the previous span
    prev = 1'b0;
    repeat (3 * RI) begin
      @(negedge i_clock);
      if (prev && !o_pins.row_strobe_n) n++;
      if (!o_pins.col_strobe_n) cas_low = 1'b1;
      prev = o_pins.row_strobe_n;
    end
    `CHK("refresh count", 1'b1, n >= 2 && n <= 3)
    `CHK("refresh column", 1'b0, cas_low)
    `CHK("device misuse", 1'b0, merr)
    $display("test refresh done");
  endtask : t_refresh
  task automatic test_done;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : test_done
  initial begin
    #(40000 * 5);
    miscompares++;
    test_done();
  end
  initial begin
    miscompares = 0;
    n_compared  = 0;
    i_rst_n     = 1'b0;
    i_req_valid = 1'b0;
    i_req       = '0;
    slow        = 1'b0;
    repeat (20) @(posedge i_clock);
    i_rst_n <= 1'b1;
    t_init();
    t_page();
    t_rmw();
    t_fill();
    t_refresh();
    test_done();
  end
endmodule : tb_pmd_ctrl
bind pmd_ctrl pmd_ctrl_chk chk (.i_clock(i_clock), .i_rst_n(i_rst_n),
  .o_init_done(o_init_done), .o_rd_valid(o_rd_valid), .o_pins(o_pins));
